// ==== hdl/amt_alert_mask.sv ====
`default_nettype none
module amt_alert_mask
	import amt_pkg::*;
#(
	parameter bit REDUCED_VARIANT = 1'b0,
	parameter int TIMER_UNIT = TIMER_UNIT_CYCLES
) (
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	input wire logic [7:0] LIMIT_COND_ONE,
	input wire logic [7:0] LIMIT_COND_TWO,
	input wire logic [TEMP_W-1:0] REMOTE_ONE_TEMP,
	input wire logic [TEMP_W-1:0] REMOTE_TWO_TEMP,
	input wire logic MANUAL_MODE,
	input wire logic [7:0] MANUAL_DUTY,
	input wire logic TEMP_ABOVE_START,
	input wire logic PIN5_IN,
	output logic PIN5_OUT,
	output logic PIN5_OE,
	input wire logic PIN9_IN,
	output logic PIN9_OUT,
	output logic PIN9_OE,
	output logic FOURTH_TACHOMETER_INPUT,
	output logic FANS_FULL_SPEED,
	output logic CRITICAL_LATCH
);
	typedef struct packed {
		logic [2:0] pin_sync;
		logic [7:0] alert_mask_one;
		logic [7:0] alert_mask_two;
		logic [7:0] pin_and_full_speed_on_throttle_config;
		logic [7:0] throttle_timer_limit;
		logic [7:0] shared_pin_function_config;
		logic [7:0] limit_remote_one;
		logic [7:0] limit_remote_two;
		logic [7:0] status_one;
		logic [7:0] status_two;
		logic pin_level;
		logic critical_latch;
		logic [7:0] rdata;
		logic pin5_oe;
		logic pin9_oe;
		logic tach;
		logic full_speed;
	} amt_state_t;

	amt_state_t cur;
	amt_state_t next_cur;
	logic [7:0] timer_value;
	logic timer_read;
	logic throttle_active;
	logic throttle_asserted;

	// Pin 5 input is unused: it only ever drives, so it needs no sampling.
	logic pin5_unused;
	assign pin5_unused = PIN5_IN;

	assign throttle_active =
		cur.shared_pin_function_config[1:0] == FUNC_THROTTLE &&
		cur.pin_and_full_speed_on_throttle_config[BIT_THROTTLE_ENABLE];
	assign throttle_asserted = throttle_active && !cur.pin_level;
	assign timer_read = REG_RD && REG_ADDR == ADDR_THROTTLE_TIMER_VALUE;

	amt_throttle_timer #(
		.UNIT_CYCLES(TIMER_UNIT)
	) u_timer (
		.clk(CORE_CLK),
		.rstn(RSTN),
		.asserted(throttle_asserted),
		.read_strobe(timer_read),
		.value(timer_value)
	);

	function automatic logic [TEMP_W-1:0] scale_limit(input logic [7:0] lim);
		scale_limit = {lim, {TEMP_FRAC_W{1'b0}}};
	endfunction

	logic [TEMP_W-1:0] crit_temp;
	logic [TEMP_W-1:0] crit_limit;
	logic crit_above;
	logic crit_below;
	logic fan_running;
	logic timer_over;
	logic rd_one;
	logic rd_two;
	logic [7:0] cond_two;
	logic alert_req;
	logic [7:0] mask_sel;
	logic [7:0] mask_two_sel;

	always_comb begin
		next_cur = cur;
		// A change on the pin counts once stages two and three agree.
		next_cur.pin_sync = {cur.pin_sync[1:0], PIN9_IN};
		if (cur.pin_sync[1] == cur.pin_sync[2]) begin
			next_cur.pin_level = cur.pin_sync[2];
		end

		if (REG_WR) begin
			case (REG_ADDR)
				ADDR_ALERT_MASK_ONE: begin
					next_cur.alert_mask_one = REG_WDATA & MASK_ONE_VALID;
				end
				ADDR_ALERT_MASK_TWO: begin
					next_cur.alert_mask_two = REG_WDATA & MASK_TWO_VALID;
				end
				ADDR_PIN_AND_FULL_SPEED_ON_THROTTLE_CONFIG: begin
					next_cur.pin_and_full_speed_on_throttle_config = REG_WDATA;
				end
				ADDR_THROTTLE_TIMER_LIMIT: begin
					next_cur.throttle_timer_limit = REG_WDATA;
				end
				ADDR_SHARED_PIN_FUNCTION_CONFIG: begin
					next_cur.shared_pin_function_config = REG_WDATA;
				end
				ADDR_LIMIT_REMOTE_ONE: begin
					next_cur.limit_remote_one = REG_WDATA;
				end
				ADDR_LIMIT_REMOTE_TWO: begin
					next_cur.limit_remote_two = REG_WDATA;
				end
				default: begin
				end
			endcase
		end

		rd_one = REG_RD && REG_ADDR == ADDR_STATUS_ONE;
		rd_two = REG_RD && REG_ADDR == ADDR_STATUS_TWO;

		// The timer condition ends by itself once a timer read drops the value to the limit or below.
		timer_over = throttle_active &&
			timer_value > cur.throttle_timer_limit;

		cond_two = LIMIT_COND_TWO;
		if (cur.shared_pin_function_config[1:0] == FUNC_THROTTLE) begin
			cond_two[BIT_FAN_FOUR_OR_TIMER] = timer_over;
		end
		cond_two[BIT_CRITICAL] = 1'b0;

		crit_temp = cur.shared_pin_function_config[BIT_LATCH_SELECT_REMOTE_TWO]
			? REMOTE_TWO_TEMP : REMOTE_ONE_TEMP;
		crit_limit = cur.shared_pin_function_config[BIT_LATCH_SELECT_REMOTE_TWO]
			? scale_limit(cur.limit_remote_two)
			: scale_limit(cur.limit_remote_one);
		// One fractional step above the limit is the first trip point.
		crit_above = REDUCED_VARIANT && crit_temp > crit_limit;
		crit_below = crit_temp < crit_limit;
		cond_two[BIT_CRITICAL] = crit_above;

		// Sticky except overtemperature: set wins over a read, and a read only clears a gone event.
		next_cur.status_one[6:1] = (LIMIT_COND_ONE[6:1] |
			(cur.status_one[6:1] & {6{~rd_one}})) &
			STATUS_ONE_VALID[6:1];
		next_cur.status_one[0] = 1'b0;
		next_cur.status_two = (cond_two |
			(cur.status_two & {8{~rd_two}})) & STATUS_TWO_STICKY;
		next_cur.status_two[BIT_CRITICAL] = REDUCED_VARIANT &&
			(crit_above || (cur.status_two[BIT_CRITICAL] && !rd_two));
		next_cur.status_two[BIT_OVERTEMP] = LIMIT_COND_TWO[BIT_OVERTEMP];
		next_cur.status_one[BIT_SUMMARY] = |next_cur.status_two;

		if (crit_above) begin
			next_cur.critical_latch = 1'b1;
		end else if (crit_below && !cur.status_two[BIT_CRITICAL]) begin
			next_cur.critical_latch = 1'b0;
		end
		if (!REDUCED_VARIANT) begin
			next_cur.critical_latch = 1'b0;
		end

		mask_sel = cur.alert_mask_one;
		mask_two_sel = cur.alert_mask_two;
		alert_req = |(next_cur.status_one[6:1] & ~mask_sel[6:1] &
			MASK_ONE_VALID[6:1]);
		alert_req = alert_req | |(next_cur.status_two[7:1] &
			~mask_two_sel[7:1]);
		// Summary path lets second-register events through all masks there.
		alert_req = alert_req | (next_cur.status_one[BIT_SUMMARY] &
			~mask_sel[BIT_SUMMARY]);

		if (REDUCED_VARIANT) begin
			next_cur.pin5_oe = next_cur.critical_latch;
		end else begin
			next_cur.pin5_oe = alert_req &&
				cur.pin_and_full_speed_on_throttle_config[BIT_ALERT_ENABLE];
		end

		case (cur.shared_pin_function_config[1:0])
			FUNC_ALERT: begin
				next_cur.pin9_oe = alert_req;
				next_cur.tach = 1'b1;
			end
			FUNC_TACH: begin
				next_cur.pin9_oe = 1'b0;
				next_cur.tach = cur.pin_level;
			end
			FUNC_THROTTLE: begin
				next_cur.pin9_oe = 1'b0;
				next_cur.tach = 1'b1;
			end
			FUNC_GPIO: begin
				next_cur.pin9_oe = 1'b0;
				next_cur.tach = 1'b1;
			end
			default: begin
				next_cur.pin9_oe = 1'b0;
				next_cur.tach = 1'b1;
			end
		endcase

		fan_running = MANUAL_MODE ? MANUAL_DUTY != 8'h00
			: TEMP_ABOVE_START;
		next_cur.full_speed = (fan_running && throttle_asserted &&
			cur.pin_and_full_speed_on_throttle_config[BIT_FULL_SPEED_ON_THROTTLE]) ||
			(next_cur.critical_latch &&
			!cur.shared_pin_function_config[BIT_LATCH_FULL_SPEED_ON_THROTTLE_DISABLE]);

		next_cur.rdata = 8'h00;
		if (REG_RD) begin
			case (REG_ADDR)
				ADDR_STATUS_ONE: next_cur.rdata = cur.status_one;
				ADDR_STATUS_TWO: next_cur.rdata = cur.status_two;
				ADDR_ALERT_MASK_ONE: next_cur.rdata = cur.alert_mask_one;
				ADDR_ALERT_MASK_TWO: next_cur.rdata = cur.alert_mask_two;
				ADDR_PIN_AND_FULL_SPEED_ON_THROTTLE_CONFIG: begin
					next_cur.rdata = cur.pin_and_full_speed_on_throttle_config;
				end
				ADDR_THROTTLE_TIMER_VALUE: next_cur.rdata = timer_value;
				ADDR_THROTTLE_TIMER_LIMIT: begin
					next_cur.rdata = cur.throttle_timer_limit;
				end
				ADDR_SHARED_PIN_FUNCTION_CONFIG: begin
					next_cur.rdata = cur.shared_pin_function_config;
				end
				ADDR_LIMIT_REMOTE_ONE: next_cur.rdata = cur.limit_remote_one;
				ADDR_LIMIT_REMOTE_TWO: next_cur.rdata = cur.limit_remote_two;
				default: next_cur.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			cur <= '0;
			cur.pin_sync <= 3'h7;
			cur.pin_level <= 1'b1;
			cur.tach <= 1'b1;
			cur.alert_mask_one <= RESET_MASK;
			cur.alert_mask_two <= RESET_MASK;
			cur.pin_and_full_speed_on_throttle_config <= RESET_PIN_AND_FULL_SPEED_ON_THROTTLE;
			cur.throttle_timer_limit <= RESET_TIMER_LIMIT;
			cur.shared_pin_function_config <= RESET_SHARED_PIN;
			cur.limit_remote_one <= RESET_LIMIT_REMOTE_ONE;
			cur.limit_remote_two <= RESET_LIMIT_REMOTE_TWO;
		end else begin
			cur <= next_cur;
		end
	end

	// Open-drain pins only ever pull low; the board supplies the high level.
	assign PIN5_OUT = 1'b0;
	assign PIN9_OUT = 1'b0;
	assign PIN5_OE = cur.pin5_oe;
	assign PIN9_OE = cur.pin9_oe;
	assign REG_RDATA = cur.rdata;
	assign FOURTH_TACHOMETER_INPUT = cur.tach;
	assign FANS_FULL_SPEED = cur.full_speed;
	assign CRITICAL_LATCH = cur.critical_latch;
endmodule : amt_alert_mask
`default_nettype wire

// ==== hdl/amt_pkg.sv ====
// Contract
// - Masking blocks only the alert, never the status
// - Mask one bits 6,5,4,2,1 gate channel alerts
// - Mask one bit 7 gates second-status summary alert
// - Mask two bits 7,6,4,3,2,1 gate their alerts
// - Mask two bit 5 gates fan four/timer
// - Alert off after reset; config three bit 0
// - Config four bits 1:0 pick shared pin function
// - Throttle needs config three bit 1 set
// - Reduced variant latch sets 0.25 above limit
// - Latch holds until below limit and flag cleared
// - Reduced variant limits reset to 136 and 100
// - Full_speed_on_throttle drives fans full while throttle low
// - Full_speed_on_throttle only when a fan already runs
// - Timer accumulates total throttle assertion time
// - Timer clears on read and saturates
// - Bit 0 first assertion, then 22.76 ms steps
// - Read during assertion restarts at one
// - Read during assertion, zero limit, flag again
// - Status bits other than overtemperature are sticky
// - Overtemperature flag and its alert not sticky
// - Timer above limit sets fan four/timer flag
`default_nettype none
package amt_pkg;
	localparam logic [7:0] ADDR_STATUS_ONE = 8'h41;
	localparam logic [7:0] ADDR_STATUS_TWO = 8'h42;
	localparam logic [7:0] ADDR_LIMIT_REMOTE_ONE = 8'h6A;
	localparam logic [7:0] ADDR_LIMIT_REMOTE_TWO = 8'h6C;
	localparam logic [7:0] ADDR_ALERT_MASK_ONE = 8'h74;
	localparam logic [7:0] ADDR_ALERT_MASK_TWO = 8'h75;
	localparam logic [7:0] ADDR_PIN_AND_FULL_SPEED_ON_THROTTLE_CONFIG = 8'h78;
	localparam logic [7:0] ADDR_THROTTLE_TIMER_VALUE = 8'h79;
	localparam logic [7:0] ADDR_THROTTLE_TIMER_LIMIT = 8'h7A;
	localparam logic [7:0] ADDR_SHARED_PIN_FUNCTION_CONFIG = 8'h7D;
	localparam logic [7:0] STATUS_ONE_VALID = 8'h76;
	localparam logic [7:0] STATUS_TWO_STICKY = 8'hFC;
	localparam logic [7:0] MASK_ONE_VALID = 8'hF6;
	localparam logic [7:0] MASK_TWO_VALID = 8'hFE;
	localparam int BIT_SUMMARY = 7;
	localparam int BIT_FAN_FOUR_OR_TIMER = 5;
	localparam int BIT_OVERTEMP = 1;
	localparam int BIT_CRITICAL = 0;
	localparam int BIT_ALERT_ENABLE = 0;
	localparam int BIT_THROTTLE_ENABLE = 1;
	localparam int BIT_FULL_SPEED_ON_THROTTLE = 2;
	localparam int BIT_LATCH_FULL_SPEED_ON_THROTTLE_DISABLE = 2;
	localparam int BIT_LATCH_SELECT_REMOTE_TWO = 3;
	localparam logic [1:0] FUNC_THROTTLE = 2'h0;
	localparam logic [1:0] FUNC_TACH = 2'h1;
	localparam logic [1:0] FUNC_GPIO = 2'h2;
	localparam logic [1:0] FUNC_ALERT = 2'h3;
	localparam logic [7:0] RESET_MASK = 8'h00;
	localparam logic [7:0] RESET_PIN_AND_FULL_SPEED_ON_THROTTLE = 8'h00;
	localparam logic [7:0] RESET_SHARED_PIN = 8'h01;
	localparam logic [7:0] RESET_TIMER_LIMIT = 8'h00;
	localparam logic [7:0] RESET_LIMIT_REMOTE_ONE = 8'h64;
	localparam logic [7:0] RESET_LIMIT_REMOTE_TWO = 8'h88;
	localparam int TEMP_W = 10;
	localparam int TEMP_FRAC_W = 2;
	localparam real CLK_PERIOD_NS = 4.0;
	localparam real TIMER_UNIT_MS = 22.76;
	localparam int TIMER_UNIT_CYCLES =
		int'(TIMER_UNIT_MS * 1.0E6 / CLK_PERIOD_NS);
	localparam int PRESCALE_W = 23;
	localparam logic [7:0] TIMER_FULL = 8'hFF;
	localparam logic [7:0] TIMER_FIRST_STEP = 8'h02;
endpackage : amt_pkg
`default_nettype wire

// ==== hdl/amt_throttle_timer.sv ====
`default_nettype none
module amt_throttle_timer
	import amt_pkg::*;
#(
	parameter int UNIT_CYCLES = TIMER_UNIT_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic asserted,
	input wire logic read_strobe,
	output logic [7:0] value
);
	typedef struct packed {
		logic [PRESCALE_W-1:0] prescale;
		logic [7:0] units;
		logic seen;
		logic [7:0] value;
	} amt_timer_state_t;

	localparam logic [PRESCALE_W-1:0] LAST_COUNT =
		PRESCALE_W'(UNIT_CYCLES - 1);

	amt_timer_state_t cur;
	amt_timer_state_t next_cur;

	always_comb begin
		next_cur = cur;
		if (read_strobe) begin
			// Restart from nothing; an active assertion shows again at once.
			next_cur.prescale = '0;
			next_cur.units = 8'h00;
			next_cur.seen = asserted;
		end else if (asserted) begin
			next_cur.seen = 1'b1;
			// The prescaler only moves while asserted, so time accumulates.
			if (cur.prescale == LAST_COUNT) begin
				next_cur.prescale = '0;
				if (cur.units != TIMER_FULL) begin
					next_cur.units = cur.units + 8'h01;
				end
			end else begin
				next_cur.prescale = cur.prescale + PRESCALE_W'(1);
			end
		end
		// Below two whole units the value reads as one once asserted.
		if (next_cur.units >= TIMER_FIRST_STEP) begin
			next_cur.value = next_cur.units;
		end else begin
			next_cur.value = {7'h00, next_cur.seen};
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign value = cur.value;
endmodule : amt_throttle_timer
`default_nettype wire

// ==== dv/amt_alert_mask_props.sv ====
`default_nettype none
module amt_alert_mask_chk
	import amt_pkg::*;
#(
	parameter bit REDUCED_VARIANT = 1'b0
) (
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic [7:0] LIMIT_COND_ONE,
	input wire logic MANUAL_MODE,
	input wire logic [7:0] MANUAL_DUTY,
	input wire logic TEMP_ABOVE_START,
	input wire logic PIN9_IN,
	input wire logic PIN5_OE,
	input wire logic PIN9_OE,
	input wire logic FOURTH_TACHOMETER_INPUT,
	input wire logic FANS_FULL_SPEED
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RSTN);
	logic [1:0] fn;
	logic [7:0] c3;
	logic [7:0] m1;
	logic fan_off;
	logic rdt;
	assign fan_off = MANUAL_MODE ? MANUAL_DUTY == 8'h00 : !TEMP_ABOVE_START;
	assign rdt = REG_RD && REG_ADDR == ADDR_THROTTLE_TIMER_VALUE;
	// Shadows of pin function, config three and mask one, updated on the same edge as the block.
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			fn <= FUNC_TACH;
			c3 <= 8'h00;
			m1 <= 8'h00;
		end else if (REG_WR &&
			REG_ADDR == ADDR_SHARED_PIN_FUNCTION_CONFIG) begin
			fn <= REG_WDATA[1:0];
		end else if (REG_WR && REG_ADDR == ADDR_PIN_AND_FULL_SPEED_ON_THROTTLE_CONFIG) begin
			c3 <= REG_WDATA;
		end else if (REG_WR && REG_ADDR == ADDR_ALERT_MASK_ONE) begin
			m1 <= REG_WDATA & MASK_ONE_VALID;
		end
	end
	property p_reset_quiet;
		$rose(RSTN) |-> !PIN5_OE && !PIN9_OE && FOURTH_TACHOMETER_INPUT;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("outputs active right after reset");
	property p_pin5_off;
		!REDUCED_VARIANT && !c3[0] && !$past(c3[0]) |-> !PIN5_OE;
	endproperty
	a_pin5_off: assert property (p_pin5_off)
		else $error("pin 5 alert driven while disabled");
	property p_pin9_func;
		fn != FUNC_ALERT && $past(fn) != FUNC_ALERT |-> !PIN9_OE;
	endproperty
	a_pin9_func: assert property (p_pin9_func)
		else $error("pin 9 driven outside alert function");
	property p_tach_idle;
		fn != FUNC_TACH && $past(fn) != FUNC_TACH |-> FOURTH_TACHOMETER_INPUT;
	endproperty
	a_tach_idle: assert property (p_tach_idle)
		else $error("tachometer input not idle");
	property p_fan_off;
		!REDUCED_VARIANT && $past(fan_off) |-> !FANS_FULL_SPEED;
	endproperty
	a_fan_off: assert property (p_fan_off)
		else $error("full_speed_on_throttle with fan stopped");
	property p_pin_high;
		(!REDUCED_VARIANT && PIN9_IN) [*8] |-> !FANS_FULL_SPEED;
	endproperty
	a_pin_high: assert property (p_pin_high)
		else $error("full_speed_on_throttle without throttle pin low");
	property p_read_clear;
		PIN9_IN [*5] ##1 (rdt && PIN9_IN) ##1 PIN9_IN ##1 rdt
			|=> REG_RDATA == 8'h00;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("timer not cleared by read");
	property p_alert_raise;
		fn == FUNC_ALERT && $past(fn) == FUNC_ALERT &&
			|(LIMIT_COND_ONE & ~m1 & STATUS_ONE_VALID) |-> ##[1:2] PIN9_OE;
	endproperty
	a_alert_raise: assert property (p_alert_raise)
		else $error("unmasked source gave no alert");
	c_timer_read: cover property (rdt ##1 REG_RDATA != 8'h00);
	c_alert: cover property ($rose(PIN9_OE));
	c_full_speed_on_throttle: cover property ($rose(FANS_FULL_SPEED));
endmodule // amt_alert_mask_chk
bind amt_alert_mask amt_alert_mask_chk #(
	.REDUCED_VARIANT(REDUCED_VARIANT)
) u_chk (
	.CORE_CLK(CORE_CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
	.REG_RDATA(REG_RDATA), .LIMIT_COND_ONE(LIMIT_COND_ONE),
	.MANUAL_MODE(MANUAL_MODE), .MANUAL_DUTY(MANUAL_DUTY),
	.TEMP_ABOVE_START(TEMP_ABOVE_START), .PIN9_IN(PIN9_IN),
	.PIN5_OE(PIN5_OE), .PIN9_OE(PIN9_OE),
	.FOURTH_TACHOMETER_INPUT(FOURTH_TACHOMETER_INPUT),
	.FANS_FULL_SPEED(FANS_FULL_SPEED));
`default_nettype wire

// ==== dv/amt_supervisor.sv ====
`default_nettype none
module amt_supervisor (
	input wire logic hold_low,
	input wire logic pin5_oe,
	input wire logic pin9_oe,
	output logic pin5,
	output logic pin9
);
	timeunit 1ns;
	timeprecision 1ps;
	// Both lines have board pull-ups, so a released line reads high.
	assign pin5 = !pin5_oe;
	// The supervisor pulls the shared pin low to ask for throttling.
	assign pin9 = !(pin9_oe || hold_low);
endmodule // amt_supervisor
`default_nettype wire

// ==== dv/tb_alert_mask_throttle_timer_value.sv ====
`default_nettype none
module tb_alert_mask_throttle_timer_value;
	import amt_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, rq = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, c1 = 8'h00, c2 = 8'h00;
	logic [7:0] duty = 8'h01, rdata, m1, m2, v1, v2;
	logic mode = 1'b1, hold = 1'b0, p5oe, p9oe, p5, p9, tach, full;
	logic [9:0] t1 = 10'h000;
	logic [7:0] rdata2;
	logic p5oe2, p9oe2, tach2, full2, crit2;
	logic [31:0] seed = 32'h8E7AD476;
	logic [7:0] exp_q[$];
	int errors = 0, checked = 0;
	amt_alert_mask #(.TIMER_UNIT(8)) DUT (
		.CORE_CLK(clk), .RSTN(rstn), .REG_ADDR(addr), .REG_WR(wr),
		.REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
		.LIMIT_COND_ONE(c1), .LIMIT_COND_TWO(c2),
		.REMOTE_ONE_TEMP(10'h000), .REMOTE_TWO_TEMP(10'h000),
		.MANUAL_MODE(mode), .MANUAL_DUTY(duty), .TEMP_ABOVE_START(1'b0),
		.PIN5_IN(p5), .PIN5_OUT(), .PIN5_OE(p5oe), .PIN9_IN(p9),
		.PIN9_OUT(), .PIN9_OE(p9oe), .FOURTH_TACHOMETER_INPUT(tach),
		.FANS_FULL_SPEED(full), .CRITICAL_LATCH());
	// The reduced variant sees the same bus; only its remote one moves.
	amt_alert_mask #(.REDUCED_VARIANT(1'b1), .TIMER_UNIT(8)) DUT_REDUCED (
		.CORE_CLK(clk), .RSTN(rstn), .REG_ADDR(addr), .REG_WR(wr),
		.REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata2),
		.LIMIT_COND_ONE(c1), .LIMIT_COND_TWO(c2),
		.REMOTE_ONE_TEMP(t1), .REMOTE_TWO_TEMP(10'h000),
		.MANUAL_MODE(mode), .MANUAL_DUTY(duty), .TEMP_ABOVE_START(1'b0),
		.PIN5_IN(p5), .PIN5_OUT(), .PIN5_OE(p5oe2), .PIN9_IN(p9),
		.PIN9_OUT(), .PIN9_OE(p9oe2), .FOURTH_TACHOMETER_INPUT(tach2),
		.FANS_FULL_SPEED(full2), .CRITICAL_LATCH(crit2));
	amt_supervisor host (.hold_low(hold), .pin5_oe(p5oe), .pin9_oe(p9oe),
		.pin5(p5), .pin9(p9));
	initial begin
		forever #2 clk = ~clk;
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] e);
		checked++;
		if (got !== e) begin
			errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, e);
		end
	endtask
	// By reference, so the level is taken at the falling edge, not the call.
	task automatic cmp1(ref logic got, input logic e);
		@(negedge clk);
		cmp8({7'h00, got}, {7'h00, e});
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Read data is valid only in the cycle after the strobe is taken.
	always @(posedge clk) begin
		rq <= rd;
	end
	always @(negedge clk) begin
		if (rq) cmp8(rdata, exp_q.pop_front());
	end
	initial begin
		tick(12);
		rstn <= 1'b1;
		wreg(8'h79, 8'hFF);
		rreg(8'h74, 8'h00);
		rreg(8'h75, 8'h00);
		rreg(8'h78, 8'h00);
		rreg(8'h79, 8'h00);
		rreg(8'h7D, 8'h01);
		rreg(8'h6A, 8'h64);
		rreg(8'h6C, 8'h88);
		rreg(8'h00, 8'h00);
		wreg(8'h74, 8'hFF);
		wreg(8'h75, 8'hFF);
		rreg(8'h74, 8'hF6);
		rreg(8'h75, 8'hFE);
		$display("test reset_and_access done");
		wreg(8'h7D, 8'h03);
		for (int i = 0; i < 8; i++) begin
			m1 = rnd() & 8'hF6;
			m2 = rnd() & 8'hFE;
			v1 = rnd() & 8'h76;
			v2 = rnd() & 8'hFE;
			wreg(8'h74, m1);
			wreg(8'h75, m2);
			c1 <= v1;
			c2 <= v2;
			tick(4);
			cmp1(p9oe, |(v1 & ~m1) | |(v2 & ~m2) | (|v2 & ~m1[7]));
			rreg(8'h41, v1 | {|v2, 7'h00});
			rreg(8'h42, v2);
			c1 <= 8'h00;
			c2 <= 8'h00;
			tick(4);
			rreg(8'h41, v1 | {|(v2 & 8'hFC), 7'h00});
			rreg(8'h42, v2 & 8'hFC);
			tick(3);
			cmp1(p9oe, 1'b0);
		end
		$display("test masks done");
		wreg(8'h74, 8'h00);
		wreg(8'h75, 8'h00);
		wreg(8'h7D, 8'h00);
		wreg(8'h78, 8'h05);
		duty <= rnd() | 8'h01;
		hold <= 1'b1;
		tick(10);
		cmp1(full, 1'b0);
		tick(1);
		hold <= 1'b0;
		tick(8);
		wreg(8'h78, 8'h07);
		hold <= 1'b1;
		tick(10);
		cmp1(full, 1'b1);
		cmp1(p5oe, 1'b1);
		tick(9);
		hold <= 1'b0;
		tick(8);
		cmp1(full, 1'b0);
		@(posedge clk);
		hold <= 1'b1;
		tick(20);
		hold <= 1'b0;
		tick(8);
		rreg(8'h79, 8'h05);
		rreg(8'h79, 8'h00);
		rreg(8'h42, 8'h20);
		tick(3);
		cmp1(p5oe, 1'b0);
		$display("test timer done");
		@(posedge clk);
		duty <= 8'h00;
		hold <= 1'b1;
		tick(30);
		cmp1(full, 1'b0);
		rreg(8'h79, 8'h03);
		rreg(8'h79, 8'h01);
		rreg(8'h42, 8'h20);
		tick(2100);
		hold <= 1'b0;
		tick(8);
		rreg(8'h79, 8'hFF);
		rreg(8'h79, 8'h00);
		tick(3);
		$display("test restart_and_saturate done");
		// One step above the remote one limit of 100 degrees trips the latch.
		@(posedge clk);
		t1 <= 10'h191;
		tick(3);
		cmp1(crit2, 1'b1);
		cmp1(p5oe2, 1'b1);
		cmp1(full2, 1'b1);
		@(posedge clk);
		t1 <= 10'h000;
		tick(4);
		cmp1(crit2, 1'b1);
		rreg(8'h42, 8'h20);
		@(negedge clk);
		cmp8(rdata2, 8'h21);
		tick(3);
		cmp1(crit2, 1'b0);
		cmp1(full2, 1'b0);
		$display("test critical_latch done");
		finish_test();
	end
	initial begin
		tick(20000);
		errors++;
		finish_test();
	end
endmodule // tb_alert_mask_throttle_timer_value
`default_nettype wire
